// [logic/dcov_pkg.sv]
package dcov_pkg;
   // overlay control register: word address of the register on the cpu bus
   localparam logic [31:0] DCOV_OCTL_ADDR = 32'hf87ffbe0;
   // field positions: shadow field in the lower half, flush, start and confirm bits in the upper half
   localparam int DCOV_SHADOW_LSB = 0;
   localparam int DCOV_SHADOW_W = 16;
   localparam int DCOV_FLUSH_BIT = 16;
   localparam int DCOV_START_BIT = 18;
   localparam int DCOV_CONFIRM_BIT = 24;
   // value software places in the upper half to request the invalidate
   localparam logic [15:0] DCOV_REQ_UPPER = 16'h0305;
   localparam logic [31:0] DCOV_OCTL_RESET = 32'h00000000;
   // controller register map
   localparam logic [3:0] DCOV_R_CMD = 4'h0;
   localparam logic [3:0] DCOV_R_STAT = 4'h1;
   localparam logic [3:0] DCOV_R_SHADOW = 4'h2;
   localparam int DCOV_CMD_GO = 0;
   typedef enum logic [2:0] {
      DCOV_IDLE, DCOV_RD, DCOV_RDW, DCOV_SYNC, DCOV_WR, DCOV_CHK, DCOV_CHKW
   } dcov_seq_t;
endpackage : dcov_pkg

// [logic/dcov_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface dcov_if;
   // cpu word bus to the overlay control register
   logic [31:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   // store pipeline: set while stores are pending, sync request, interrupt hold-off
   logic store_busy;
   logic sync_req;
   logic irq_off;
   modport dev (input addr, wdata, wr, rd, sync_req, irq_off, output rdata, store_busy);
   modport host (output addr, wdata, wr, rd, sync_req, irq_off, input rdata, store_busy);
endinterface : dcov_if
`default_nettype wire

// [logic/dcov_cache.sv]
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dcov_cache
   import dcov_pkg::*;
#(
   parameter int LINES = 16,
   parameter int IDX_W = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // overlay control side
   dcov_if.dev bus,
   // store pipeline
   input wire logic st_valid,
   input wire logic [IDX_W-1:0] st_line,
   input wire logic fill_valid,
   input wire logic [IDX_W-1:0] fill_line,
   input wire logic st_pending,
   // line state
   output logic [LINES-1:0] line_valid,
   output logic [LINES-1:0] line_dirty,
   output logic flush_pulse
);
   // line state
   logic [LINES-1:0] valid_q;
   logic [LINES-1:0] valid_d;
   logic [LINES-1:0] dirty_q;
   logic [LINES-1:0] dirty_d;
   // overlay control register and its read port
   logic [31:0] octl_q;
   logic [31:0] octl_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   // flush marker and drain status
   logic flush_q;
   logic flush_d;
   logic busy_q;
   logic busy_d;
   // decoded bus requests
   logic wr_hit;
   logic rd_hit;
   logic flush;

   // whole-word match; the bus carries no byte lanes
   function automatic logic octl_match(input logic [31:0] a);
      octl_match = (a == DCOV_OCTL_ADDR);
   endfunction : octl_match

   // one index compare serves both the store and the refill port
   function automatic logic line_hit(
      input logic req,
      input logic [IDX_W-1:0] idx,
      input int unsigned line
   );
      line_hit = req && (idx == IDX_W'(line));
   endfunction : line_hit

   // next {valid, dirty} of one line from this cycle's events
   function automatic logic [1:0] line_step(
      input logic valid,
      input logic dirty,
      input logic inval,
      input logic fill,
      input logic store
   );
      logic [1:0] nxt;
      nxt = {valid, dirty};
      case ({store, fill, inval})
         3'h0: nxt = {valid, dirty};
         // dirty lines hold write-back data, so the flush skips them
         3'h1: nxt = dirty ? {valid, dirty} : 2'h0;
         // refill sets the line valid and leaves its dirty bit as it was
         3'h2: nxt = {1'b1, dirty};
         // refill beats the flush: its data is already fresh
         3'h3: nxt = {1'b1, dirty};
         // store leaves the line valid and dirty from either clean state
         3'h4: nxt = 2'h3;
         // store beats a same-cycle flush, else its data sits in a dead line
         3'h5: nxt = 2'h3;
         3'h6: nxt = 2'h3;
         3'h7: nxt = 2'h3;
         default: nxt = {valid, dirty};
      endcase
      line_step = nxt;
   endfunction : line_step

   assign wr_hit = bus.wr && octl_match(bus.addr);
   assign rd_hit = bus.rd && octl_match(bus.addr);
   assign flush = wr_hit && bus.wdata[DCOV_FLUSH_BIT];

   always_comb begin
      octl_d = octl_q;
      rdata_d = 32'h00000000;
      if (wr_hit) begin
         octl_d = bus.wdata;
         // request self-clears, so a readback cannot start a second flush
         octl_d[DCOV_FLUSH_BIT] = 1'b0;
         // confirm shows only once the invalidate really ran
         octl_d[DCOV_CONFIRM_BIT] = bus.wdata[DCOV_FLUSH_BIT];
      end
      // zero outside the answer cycle
      if (rd_hit) begin
         rdata_d = octl_q;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         octl_q <= DCOV_OCTL_RESET;
         rdata_q <= 32'h00000000;
      end else begin
         octl_q <= octl_d;
         rdata_q <= rdata_d;
      end
   end

   // read-only lines are clean, so discarding them loses nothing
   generate
      for (genvar i = 0; i < LINES; i++) begin : g_line
         always_comb begin
            {valid_d[i], dirty_d[i]} = line_step(
               valid_q[i],
               dirty_q[i],
               flush,
               line_hit(fill_valid, fill_line, i),
               line_hit(st_valid, st_line, i)
            );
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         valid_q <= '0;
         dirty_q <= '0;
      end else begin
         valid_q <= valid_d;
         dirty_q <= dirty_d;
      end
   end

   always_comb begin
      flush_d = flush;
      // a store issued now is still in flight next cycle
      busy_d = st_pending | st_valid;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         flush_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         flush_q <= flush_d;
         busy_q <= busy_d;
      end
   end

   assign line_valid = valid_q;
   assign line_dirty = dirty_q;
   assign flush_pulse = flush_q;
   assign bus.rdata = rdata_q;
   assign bus.store_busy = busy_q;
endmodule : dcov_cache
`default_nettype wire

// [logic/dcov_sw.sv]
`timescale 1ns/1ps
`default_nettype none
module dcov_sw
   import dcov_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // software register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // overlay control side
   dcov_if.host bus
);
   dcov_seq_t st_q, st_d;
   logic [31:0] addr_q, addr_d, wdata_q, wdata_d, shadow_q, shadow_d, rdata_q, rdata_d;
   logic wr_q, wr_d, rd_q, rd_d, sync_q, sync_d, irq_q, irq_d, done_q, done_d;

   always_comb begin
      st_d = st_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      shadow_d = shadow_q;
      wr_d = 1'b0;
      rd_d = 1'b0;
      sync_d = 1'b0;
      irq_d = irq_q;
      done_d = done_q;
      rdata_d = 32'h00000000;
      case (st_q)
         DCOV_IDLE: begin
            if (reg_wr && reg_addr == DCOV_R_CMD && reg_wdata[DCOV_CMD_GO]) begin
               irq_d = 1'b1; // interrupts held off for the whole run
               done_d = 1'b0;
               addr_d = DCOV_OCTL_ADDR;
               rd_d = 1'b1;
               st_d = DCOV_RD;
            end
         end
         DCOV_RD: st_d = DCOV_RDW;
         DCOV_RDW: begin
            // keep shadow enables, set request bits in upper half
            wdata_d = {DCOV_REQ_UPPER, bus.rdata[DCOV_SHADOW_W-1:0]};
            shadow_d = bus.rdata;
            st_d = DCOV_SYNC;
         end
         DCOV_SYNC: begin
            sync_d = 1'b1;
            // one sync cycle first, so the drain status is up to date
            if (!bus.store_busy && sync_q) begin
               wr_d = 1'b1; // stores drained first
               st_d = DCOV_WR;
            end
         end
         DCOV_WR: begin
            rd_d = 1'b1; // read back to close the write
            st_d = DCOV_CHK;
         end
         DCOV_CHK: st_d = DCOV_CHKW;
         DCOV_CHKW: begin
            shadow_d = bus.rdata;
            done_d = 1'b1;
            irq_d = 1'b0;
            st_d = DCOV_IDLE;
         end
         default: st_d = DCOV_IDLE;
      endcase
      if (reg_rd) begin
         case (reg_addr)
            DCOV_R_STAT: rdata_d = {30'h00000000, irq_q, done_q};
            DCOV_R_SHADOW: rdata_d = shadow_q;
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= DCOV_IDLE;
         addr_q <= 32'h00000000;
         wdata_q <= 32'h00000000;
         shadow_q <= 32'h00000000;
         rdata_q <= 32'h00000000;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         sync_q <= 1'b0;
         irq_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         shadow_q <= shadow_d;
         rdata_q <= rdata_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         sync_q <= sync_d;
         irq_q <= irq_d;
         done_q <= done_d;
      end
   end

   assign bus.addr = addr_q;
   assign bus.wdata = wdata_q;
   assign bus.wr = wr_q;
   assign bus.rd = rd_q;
   assign bus.sync_req = sync_q;
   assign bus.irq_off = irq_q;
   assign reg_rdata = rdata_q;
endmodule : dcov_sw
`default_nettype wire

// [verif/dcov_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module dcov_monitor
   import dcov_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // overlay bus
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic store_busy,
   input wire logic sync_req,
   input wire logic irq_off
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // lower half of the last value read, for the shadow field
   logic rd_q;
   logic [15:0] shadow_q;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rd_q <= 1'b0;
         shadow_q <= 16'h0000;
      end else begin
         rd_q <= rd;
         if (rd_q) shadow_q <= rdata[15:0];
      end
   end
   property p_addr; (wr || rd) |-> addr == DCOV_OCTL_ADDR; endproperty
   a_addr: assert property (p_addr) else $error("access off register");
   property p_upper; wr |-> wdata[31:16] == DCOV_REQ_UPPER; endproperty
   a_upper: assert property (p_upper) else $error("bad upper half");
   property p_shadow; wr |-> wdata[15:0] == shadow_q; endproperty
   a_shadow: assert property (p_shadow) else $error("shadow field lost");
   property p_drain; wr |-> !store_busy; endproperty
   a_drain: assert property (p_drain) else $error("write with stores pending");
   property p_irq; (wr || sync_req) |-> irq_off; endproperty
   a_irq: assert property (p_irq) else $error("interrupts not held off");
   property p_back; wr |=> ##[0:3] rd; endproperty
   a_back: assert property (p_back) else $error("no readback");
   property p_conf; rd && $past(wr) |=> rdata[DCOV_CONFIRM_BIT]; endproperty
   a_conf: assert property (p_conf) else $error("confirm not shown");
   property p_quiet; !rd |=> rdata == 32'h00000000; endproperty
   a_quiet: assert property (p_quiet) else $error("read data outside read");
endmodule : dcov_monitor
`default_nettype wire

// [verif/dcache_overlay_invalidate_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module dcache_overlay_invalidate_tb import dcov_pkg::*;;
   logic sys_clk, rstn, reg_wr, reg_rd, st_valid, fill_valid, flush_pulse, st_pending;
   logic [3:0] reg_addr, st_line, fill_line;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [15:0] line_valid, line_dirty;
   int fail_count = 0, checked = 0, pulses = 0;
   // rows: {store, line[3:0], valid, dirty}
   logic [6:0] rows [5] = '{7'h02, 7'h06, 7'h47, 7'h4b, 7'h0e};
   dcov_if dcov_if_i();
   dcov_cache dcov_cache_i(.sys_clk, .rstn, .bus(dcov_if_i), .st_valid, .st_line,
      .fill_valid, .fill_line, .st_pending, .line_valid, .line_dirty, .flush_pulse);
   dcov_sw dcov_sw_i(.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .bus(dcov_if_i));
   dcov_monitor dcov_monitor_i(.sys_clk, .rstn, .addr(dcov_if_i.addr),
      .wdata(dcov_if_i.wdata), .wr(dcov_if_i.wr), .rd(dcov_if_i.rd),
      .rdata(dcov_if_i.rdata), .store_busy(dcov_if_i.store_busy),
      .sync_req(dcov_if_i.sync_req), .irq_off(dcov_if_i.irq_off));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (flush_pulse === 1'b1) pulses++;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rg(input logic [3:0] a, input logic w, input logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      d = reg_rdata;
   endtask : rg
   task automatic op(input logic s, input logic [3:0] l);
      @(posedge sys_clk);
      st_valid <= s;
      fill_valid <= !s;
      st_line <= l;
      fill_line <= l;
      @(posedge sys_clk);
      st_valid <= 1'b0;
      fill_valid <= 1'b0;
      @(negedge sys_clk);
   endtask : op
   // go, then poll busy with a bound so a stuck sequencer cannot hang us
   task automatic run();
      int n;
      n = 0;
      rg(DCOV_R_CMD, 1'b1, 32'h00000001);
      do begin
         rg(DCOV_R_STAT, 1'b0, 32'h0);
         n++;
      end while (d[1] !== 1'b0 && n < 30);
      chk(d[0], 1'b1);
      rg(DCOV_R_SHADOW, 1'b0, 32'h0);
      chk(d[DCOV_CONFIRM_BIT], 1'b1);
   endtask : run
   task automatic results();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   initial begin
      #200000;
      fail_count++;
      results();
   end
   initial begin
      rstn = 1'b0;
      {reg_wr, reg_rd, st_valid, fill_valid, st_pending} = 5'h00;
      {reg_addr, st_line, fill_line} = 12'h000;
      reg_wdata = 32'h0;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      @(negedge sys_clk);
      chk(line_valid | line_dirty, 32'h0);
      $display("reset test done");
      foreach (rows[i]) begin
         op(rows[i][6], rows[i][5:2]);
         chk(line_valid[rows[i][5:2]], rows[i][1]);
         chk(line_dirty[rows[i][5:2]], rows[i][0]);
      end
      $display("row test done");
      run();
      chk(line_valid, 32'h0006);
      chk(line_dirty, 32'h0006);
      chk(pulses, 32'h1);
      $display("flush test done");
      op(1'b0, 4'h3);
      // store lands in the cycle the drained sequencer writes the flush
      fork
         run();
         begin
            @(posedge sys_clk iff (dcov_if_i.sync_req && !dcov_if_i.store_busy));
            st_valid <= 1'b1;
            st_line <= 4'h0;
            @(posedge sys_clk);
            st_valid <= 1'b0;
         end
      join
      chk(line_valid, 32'h0007);
      chk(line_dirty, 32'h0007);
      $display("store race test done");
      // stores held pending: the write must wait for the drain
      op(1'b0, 4'h5);
      @(posedge sys_clk);
      st_pending <= 1'b1;
      fork
         run();
         begin
            @(posedge sys_clk iff dcov_if_i.sync_req);
            repeat (4) @(posedge sys_clk);
            chk(dcov_if_i.sync_req, 1'b1);
            chk(dcov_if_i.wr, 1'b0);
            st_pending <= 1'b0;
         end
      join
      chk(line_valid, 32'h0007);
      chk(line_dirty, 32'h0007);
      chk(pulses, 32'h3);
      $display("drain test done");
      results();
   end
endmodule : dcache_overlay_invalidate_tb
`default_nettype wire
